// ### dv/aod_diag_assertions.sv
// checker for the diagnostic record block
`timescale 1ns/1ps
module aod_diag_chk (
  input wire logic               clk_in,         // clock
  input wire logic               nrst_in,        // reset
  input wire logic               rd_en_in,       // strobe
  input wire logic [3:0]         rd_addr_in,     // index
  input wire logic               irq_release_in, // release
  input wire logic [7:0]         rd_data_out,    // byte
  input wire logic               rd_valid_out,   // answer
  input wire logic               irq_out,        // irq
  input wire logic               irq_going_out,  // going
  input wire aod_pkg::aod_basic_t basic_rec_out, // record
  input wire logic               group_lamp_out, // lamp
  input wire logic [3:0]         chan_lamp_out   // lamps
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rd(logic [3:0] a);
    rd_en_in && rd_addr_in == a;
  endsequence
  property p_byte(logic [3:0] a, logic [7:0] v);
    s_rd(a) |=> rd_valid_out && rd_data_out == v;
  endproperty
  a_class_byte: assert property (p_byte(4'h1, 8'h15)) else $error("class byte");
  a_unused_byte: assert property (p_byte(4'h3, 8'h00)) else $error("byte 3");
  a_type_byte: assert property (p_byte(4'h4, 8'h73)) else $error("type byte");
  a_bits_byte: assert property (p_byte(4'h5, 8'h08)) else $error("bits byte");
  a_count_byte: assert property (p_byte(4'h6, 8'h04)) else $error("count byte");
  a_cherr_upper: assert property (s_rd(4'h7) |=> rd_data_out[7:4] == 4'h0)
    else $error("byte 7 upper bits");
  a_read_answer: assert property (rd_en_in |=> rd_valid_out) else $error("no answer");
  a_read_quiet: assert property (!rd_en_in |=> !rd_valid_out) else $error("stray answer");
  a_irq_release: assert property (irq_out |-> $past(irq_release_in))
    else $error("irq without release");
  a_record_hold: assert property (!irq_out |-> $stable(basic_rec_out))
    else $error("record moved");
  a_going_hold: assert property (!irq_out |-> $stable(irq_going_out))
    else $error("direction moved");
  a_lamp_group: assert property (|chan_lamp_out |-> group_lamp_out)
    else $error("channel lamp alone");
endmodule : aod_diag_chk
bind aod_diag aod_diag_chk chk_u (.clk_in, .nrst_in, .rd_en_in, .rd_addr_in, .irq_release_in,
  .rd_data_out, .rd_valid_out, .irq_out, .irq_going_out, .basic_rec_out, .group_lamp_out,
  .chan_lamp_out);

// ### dv/aod_host_model.sv
// host side model: fetches record bytes one at a time over the read port
`timescale 1ns/1ps
module aod_host_model (
  input  wire logic       clk_in,      // clock
  input  wire logic       rd_valid_in, // answer pulse
  input  wire logic [7:0] rd_data_in,  // answer byte
  output logic            rd_en_out,   // read strobe
  output logic [3:0]      rd_addr_out  // byte index
);
  initial begin
    rd_en_out   = 1'b0;
    rd_addr_out = 4'hF;
  end
  // handler reads whenever called, with or without an interrupt, one byte per call
  task automatic read_byte(input logic [3:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_in);
    rd_en_out   = 1'b1;
    rd_addr_out = a;
    @(negedge clk_in);
    rd_en_out   = 1'b0;
    rd_addr_out = ~a; // idle index never repeats the last one
    ok          = rd_valid_in;
    d           = rd_data_in;
  endtask : read_byte
endmodule : aod_host_model

// ### dv/tb_top.sv
// self-checking bench for the diagnostic record block
`timescale 1ns/1ps
module tb_top;
  import aod_pkg::*;
  logic            clk_in, nrst_in, irq_release_in, manual_var_in, rd_en_in;
  logic            rd_valid_out, irq_out, irq_going_out, group_lamp_out;
  logic [3:0]      group_diag_in, rd_addr_in, chan_lamp_out;
  logic [7:0]      rd_data_out;
  aod_chan_t [3:0] chan_fault_in;
  aod_module_t     mod_fault_in;
  aod_basic_t      basic_rec_out;
  int              errors, checks_done, cyc;
  logic [7:0]      dflt [16] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h73, 8'h08, 8'h04,
                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h00};
  aod_diag dut_u (.clk_in, .nrst_in, .chan_fault_in, .mod_fault_in, .group_diag_in,
    .irq_release_in, .manual_var_in, .rd_en_in, .rd_addr_in, .rd_data_out, .rd_valid_out,
    .irq_out, .irq_going_out, .basic_rec_out, .group_lamp_out, .chan_lamp_out);
  aod_host_model host_u (.clk_in, .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out),
    .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host_u.read_byte(a, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk({24'h0, d}, {24'h0, exp});
  endtask : rd
  // irq lands 4 edges after a pin change, so 8 is ample
  task automatic wait_irq(input logic exp, input logic dir);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk_in);
      if (irq_out === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, exp});
    if (exp) chk({31'h0, irq_going_out}, {31'h0, dir});
  endtask : wait_irq
  task automatic run_fault(input int c, input aod_chan_t v, input logic [7:0] det);
    chan_fault_in[c] = v;
    wait_irq(1'b1, 1'b0);
    chk(basic_rec_out, 32'h0000_1509);
    chk({group_lamp_out, chan_lamp_out}, {27'h0, 1'b1, 4'(1 << c)});
    rd(4'(8 + c), det);
    rd(4'h7, 8'(1 << c));
    chan_fault_in[c] = '0;
    wait_irq(1'b1, 1'b1);
    chk(basic_rec_out, 32'h0000_1500);
    $display("fault test ch%0d done", c);
  endtask : run_fault
  task automatic t_hand;
    manual_var_in    = 1'b1;
    chan_fault_in[1] = 4'b0010;
    chan_fault_in[3] = 4'b0010;
    wait_irq(1'b1, 1'b0);
    rd(4'h9, 8'h20);
    rd(4'h7, 8'h0A);
    chan_fault_in[1] = '0;
    wait_irq(1'b0, 1'b0);
    rd(4'h7, 8'h08);
    chan_fault_in[3] = '0;
    wait_irq(1'b1, 1'b1);
    manual_var_in    = 1'b0;
    $display("hand test done");
  endtask : t_hand
  task automatic t_module;
    mod_fault_in = 3'b111;
    wait_irq(1'b1, 1'b0);
    rd(4'h0, 8'h95);
    rd(4'h2, 8'h04);
    mod_fault_in = '0;
    wait_irq(1'b1, 1'b1);
    $display("module test done");
  endtask : t_module
  task automatic t_gates;
    irq_release_in         = 1'b0;
    chan_fault_in[0]       = 4'b1000;
    wait_irq(1'b0, 1'b0);
    chk(basic_rec_out, 32'h0000_1500);
    rd(4'h8, 8'h10);
    chan_fault_in[0]       = '0;
    // departure under release off must be dropped too
    wait_irq(1'b0, 1'b0);
    irq_release_in         = 1'b1;
    group_diag_in          = 4'h0;
    chan_fault_in[2]       = 4'b1000;
    wait_irq(1'b0, 1'b0);
    rd(4'hA, 8'h00);
    chk({31'h0, group_lamp_out}, 32'h0);
    chan_fault_in[2]       = '0;
    // let the synchroniser drain before groups come back on
    wait_irq(1'b0, 1'b0);
    group_diag_in          = 4'hF;
    $display("gate test done");
  endtask : t_gates
  task automatic t_defaults;
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), dflt[i]);
    end
    $display("default test done");
  endtask : t_defaults
  task automatic t_reset;
    chan_fault_in[1] = 4'b1000;
    wait_irq(1'b1, 1'b0);
    nrst_in          = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(basic_rec_out, 32'h0);
    chk({group_lamp_out, chan_lamp_out, irq_going_out}, 32'h0);
    nrst_in          = 1'b1;
    // the pin still shows the fault, so it must come back as an arrival
    wait_irq(1'b1, 1'b0);
    chk(basic_rec_out, 32'h0000_1509);
    rd(4'h9, 8'h10);
    chan_fault_in[1] = '0;
    wait_irq(1'b1, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    {nrst_in, manual_var_in, chan_fault_in, mod_fault_in} = '0;
    group_diag_in  = 4'hF;
    irq_release_in = 1'b1;
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    t_defaults();
    run_fault(0, 4'b1000, 8'h10);
    run_fault(2, 4'b0100, 8'h08);
    t_hand();
    t_module();
    t_gates();
    t_reset();
    close_out();
  end
endmodule : tb_top

// ### verilog/aod_defs.svh
// constants for the analog output diagnostic record block
`ifndef AOD_DEFS_SVH
`define AOD_DEFS_SVH
`define AOD_NCH          4
`define AOD_OFS_SUMMARY  4'h0
`define AOD_OFS_CLASS    4'h1
`define AOD_OFS_OPSTATE  4'h2
`define AOD_OFS_UNUSED   4'h3
`define AOD_OFS_CHTYPE   4'h4
`define AOD_OFS_BITSPER  4'h5
`define AOD_OFS_CHCOUNT  4'h6
`define AOD_OFS_CHERR    4'h7
`define AOD_OFS_CH0      4'h8
`define AOD_OFS_CH1      4'h9
`define AOD_OFS_CH2      4'hA
`define AOD_OFS_CH3      4'hB
`define AOD_B0_MODERR    0
`define AOD_B0_EXTERR    2
`define AOD_B0_CHERR     3
`define AOD_B0_NOSUPPLY  4
`define AOD_B0_BADPARAM  7
`define AOD_B2_STOP      2
`define AOD_CH_PARAM     0
`define AOD_CH_SHORT     3
`define AOD_CH_WIREBRK   4
`define AOD_CH_HAND      5
`define AOD_CLASS_VAL    8'h15
`define AOD_CHTYPE_VAL   7'h73
`define AOD_BITSPER_VAL  8'h08
`define AOD_CHCOUNT_VAL  8'h04
`define AOD_MORE_TYPES   1'h0
`define AOD_ZERO_BYTE    8'h00
`define AOD_ZERO_WORD    32'h0000_0000
`define AOD_ZERO_CH      4'h0
`endif

// ### verilog/aod_diag.sv
// diagnostic record and interrupt logic of a four-channel analog output module
`timescale 1ns/1ps
`include "aod_defs.svh"

module aod_diag (
  input  wire logic                          clk_in,          // 25 MHz clock
  input  wire logic                          nrst_in,         // sync reset, low
  input  wire aod_pkg::aod_chan_t [3:0]      chan_fault_in,   // channel faults, async
  input  wire aod_pkg::aod_module_t          mod_fault_in,    // module faults, async
  input  wire logic [3:0]                    group_diag_in,   // group diag enable
  input  wire logic                          irq_release_in,  // interrupt release
  input  wire logic                          manual_var_in,   // 1: hand-switch variant
  input  wire logic                          rd_en_in,        // record read strobe
  input  wire logic [3:0]                    rd_addr_in,      // record byte index
  output logic [7:0]                         rd_data_out,     // record byte
  output logic                               rd_valid_out,    // read answer pulse
  output logic                               irq_out,         // interrupt pulse
  output logic                               irq_going_out,   // 1: fault departed
  output aod_pkg::aod_basic_t                basic_rec_out,   // pushed basic record
  output logic                               group_lamp_out,  // group error lamp
  output logic [3:0]                         chan_lamp_out    // channel error lamps
);
  import aod_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  aod_chan_t [3:0] chan_meta;
  aod_chan_t [3:0] chan_sync;
  aod_module_t     mod_meta;
  aod_module_t     mod_sync;

  // fault lines come straight from the analog side, so two stages first
  // enables and release come from this clock and skip the stages
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      chan_meta <= '0;
      chan_sync <= '0;
      mod_meta  <= '0;
      mod_sync  <= '0;
    end else begin
      chan_meta <= chan_fault_in;
      chan_sync <= chan_meta;
      mod_meta  <= mod_fault_in;
      mod_sync  <= mod_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel fault detail

  logic [7:0] next_detail [`AOD_NCH];
  logic [3:0] next_cherr;
  logic [3:0] next_hand;

  always_comb begin
    for (int i = 0; i < `AOD_NCH; i++) begin
      next_detail[i] = `AOD_ZERO_BYTE;
      next_hand[i]   = 1'b0;
      // a channel outside group diagnostics records nothing
      // bits of the variant not fitted stay zero
      if (group_diag_in[i]) begin
        next_detail[i][`AOD_CH_PARAM] = chan_sync[i].param_err;
        if (manual_var_in) begin
          next_detail[i][`AOD_CH_HAND] = chan_sync[i].hand_mode;
          next_hand[i]                 = chan_sync[i].hand_mode;
        end else begin
          next_detail[i][`AOD_CH_SHORT]   = chan_sync[i].short_gnd;
          next_detail[i][`AOD_CH_WIREBRK] = chan_sync[i].wire_break;
        end
      end
      // hand operation counts as a channel error like any other bit
      next_cherr[i] = |next_detail[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // module summary

  logic [7:0] next_summary;
  logic       any_group;

  // module faults have no channel, so any enabled group admits them
  assign any_group = |group_diag_in;

  always_comb begin
    next_summary = `AOD_ZERO_BYTE;
    // supply and parameter faults are module-wide, gated by any group enable
    next_summary[`AOD_B0_NOSUPPLY] = any_group & mod_sync.supply_missing;
    // no external fault source besides the supply, so it mirrors that bit
    next_summary[`AOD_B0_EXTERR]   = any_group & mod_sync.supply_missing;
    next_summary[`AOD_B0_BADPARAM] = any_group & mod_sync.param_err;
    next_summary[`AOD_B0_CHERR]    = |next_cherr;
    next_summary[`AOD_B0_MODERR]   = next_summary[`AOD_B0_NOSUPPLY]
                                   | next_summary[`AOD_B0_BADPARAM]
                                   | next_summary[`AOD_B0_CHERR];
  end

  //////////////////////////////////////////////////////////////////////////////
  // record storage

  logic [7:0] summary;
  logic [7:0] opstate;
  logic [3:0] cherr;
  logic [3:0] hand;
  logic [7:0] detail [`AOD_NCH];

  // flags track their conditions every cycle, set and clear alike
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      summary <= `AOD_ZERO_BYTE;
      cherr   <= `AOD_ZERO_CH;
      hand    <= `AOD_ZERO_CH;
      for (int i = 0; i < `AOD_NCH; i++) begin
        detail[i] <= `AOD_ZERO_BYTE;
      end
    end else begin
      summary <= next_summary;
      cherr   <= next_cherr;
      // hand copies feed only event detection, arrival and departure alike
      hand    <= next_hand;
      for (int i = 0; i < `AOD_NCH; i++) begin
        detail[i] <= next_detail[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      opstate <= `AOD_ZERO_BYTE;
    end else begin
      // stop state shows whether or not diagnostics are on
      opstate                <= `AOD_ZERO_BYTE;
      opstate[`AOD_B2_STOP]  <= mod_sync.cpu_stop;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event detection and interrupt

  logic [7:0] other_now;
  logic [7:0] other_prev;
  logic       came;
  logic       went;
  aod_basic_t next_basic;

  // hand bits are left out here; they depart only as a whole group
  assign other_now  = summary;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      other_prev <= `AOD_ZERO_BYTE;
    end else begin
      other_prev <= other_now;
    end
  end

  logic [3:0] hand_prev;
  logic [3:0] nonhand_now;
  logic [3:0] nonhand_prev;
  logic [3:0] cherr_prev;
  logic       came_flag;
  logic       came_chan;
  logic       came_hand;
  logic       went_flag;
  logic       went_chan;
  logic       went_hand;
  logic       fire;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hand_prev    <= `AOD_ZERO_CH;
      cherr_prev   <= `AOD_ZERO_CH;
      nonhand_prev <= `AOD_ZERO_CH;
    end else begin
      hand_prev    <= hand;
      cherr_prev   <= cherr;
      // own copy, so a hand flag leaving with a parameter flag on one
      // channel cannot hide the parameter departure
      nonhand_prev <= nonhand_now;
    end
  end

  always_comb begin
    for (int i = 0; i < `AOD_NCH; i++) begin
      nonhand_now[i] = |(detail[i] & ~(8'h01 << `AOD_CH_HAND));
    end
  end

  // a new summary flag, a newly erroring channel or a new hand switch is an arrival
  assign came_flag = |(other_now & ~other_prev);
  assign came_chan = |(cherr & ~cherr_prev);
  assign came_hand = |(hand & ~hand_prev);
  assign came      = came_flag | came_chan | came_hand;

  // the summary channel bit is always masked here; channel departures come from went_chan and went_hand
  assign went_flag = |((other_prev & ~other_now) & ~(8'h01 << `AOD_B0_CHERR));
  assign went_chan = |(nonhand_prev & ~nonhand_now & ~hand);
  // hand operation departs as one event, once the last switch is back
  assign went_hand = (|hand_prev) & ~(|hand);
  assign went      = went_flag | went_chan | went_hand;

  // an event with release off is lost, not queued
  assign fire = irq_release_in & (came | went);

  always_comb begin
    next_basic            = '0;
    next_basic.summary    = summary;
    next_basic.class_info = `AOD_CLASS_VAL;
    next_basic.opstate    = opstate;
    next_basic.unused     = `AOD_ZERO_BYTE;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_out       <= 1'b0;
      irq_going_out <= 1'b0;
      basic_rec_out <= '0;
    end else begin
      irq_out <= fire;
      if (fire) begin
        // arrival wins when both happen together
        // the snapshot travels with the event so the host sees its cause
        irq_going_out <= ~came;
        basic_rec_out <= next_basic;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lamps

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      group_lamp_out <= 1'b0;
      chan_lamp_out  <= `AOD_ZERO_CH;
    end else begin
      // missing supply lights the group lamp even without diagnostics
      group_lamp_out <= (|summary) | mod_sync.supply_missing;
      // lamps lag the record by one edge, too short to see
      chan_lamp_out  <= cherr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // record read port

  logic [7:0] next_rd;

  always_comb begin
    next_rd = `AOD_ZERO_BYTE;
    unique case (rd_addr_in)
      `AOD_OFS_SUMMARY: next_rd = summary;
      `AOD_OFS_CLASS:   next_rd = `AOD_CLASS_VAL;
      `AOD_OFS_OPSTATE: next_rd = opstate;
      `AOD_OFS_UNUSED:  next_rd = `AOD_ZERO_BYTE;
      `AOD_OFS_CHTYPE:  next_rd = {`AOD_MORE_TYPES, `AOD_CHTYPE_VAL};
      `AOD_OFS_BITSPER: next_rd = `AOD_BITSPER_VAL;
      `AOD_OFS_CHCOUNT: next_rd = `AOD_CHCOUNT_VAL;
      `AOD_OFS_CHERR:   next_rd = {`AOD_ZERO_CH, cherr};
      `AOD_OFS_CH0:     next_rd = detail[0];
      `AOD_OFS_CH1:     next_rd = detail[1];
      `AOD_OFS_CH2:     next_rd = detail[2];
      `AOD_OFS_CH3:     next_rd = detail[3];
      // 12 to 15 are reserved and read as zero
      default:          next_rd = `AOD_ZERO_BYTE;
    endcase
  end

  // extended record stays readable regardless of interrupt release
  // reads have no side effects, so the host may poll freely
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rd_data_out  <= `AOD_ZERO_BYTE;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= next_rd;
      end
    end
  end
endmodule : aod_diag

// ### verilog/aod_pkg.sv
// types shared by the analog output diagnostic record block
package aod_pkg;
  // raw per-channel fault indications from the output stage
  typedef struct packed {
    logic wire_break;
    logic short_gnd;
    logic hand_mode;
    logic param_err;
  } aod_chan_t;

  // indications that concern the whole module
  typedef struct packed {
    logic supply_missing;
    logic param_err;
    logic cpu_stop;
  } aod_module_t;

  // the four bytes pushed to the host with every diagnostic interrupt
  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] opstate;
    logic [7:0] class_info;
    logic [7:0] summary;
  } aod_basic_t;
endpackage : aod_pkg
